//--- rtl/lamp_link_if.sv
// Interface joining master and device over the serial pins.
// Assumes the bench resolves tri-state pins from the enables.
`timescale 1ns/1ps
interface lamp_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;
  logic reset_n;
  logic wake;
  logic [3:0] direct_control_inputs;
  logic fault_indicator_n_oe_n;
  logic fault_indicator_n;

  modport device (
    input cs_n, sclk, mosi, reset_n, wake, direct_control_inputs,
    output miso_o, miso_oe_n, fault_indicator_n_oe_n
  );
  modport host (
    output cs_n, sclk, mosi, reset_n, wake, direct_control_inputs,
    input miso, fault_indicator_n
  );
endinterface

//--- rtl/lamp_link_pkg.sv
// Constants shared by both ends of the serial lamp switch link.
// Assumes both ends compile this package first.
// Contract
// RULE1: Device samples serial input on clock fall.
// RULE2: Device advances serial output on clock rise.
// RULE3: Master sends sixteen bits, MSB first, per frame.
// RULE4: Chip select rise commits frame to addressed register.
// RULE5: Chip select fall loads status into transmit shifter.
// RULE6: Output driven only while select low; else ignored.
// RULE7: Master keeps serial clock low at select edges.
// RULE8: Master keeps serial clock low while idle.
// RULE9: Five-bit address selects the written register.
// RULE10: Master respects the maximum serial clock rate.
// RULE11: Reset held low for minimum pulse time.
// RULE12: Reset wakes, clears configuration, allows sleep.
// RULE13: Reset rising edge starts the watchdog.
// RULE14: Direct inputs wake and switch their outputs.
// RULE15: External PWM clock arrives on direct input zero.
// RULE16: Fault pin pulled low on any fault.
// RULE17: Wake input brings device out of sleep.
// RULE18: Sense output selectable and tri-statable by command.
// RULE19: Sleep treats all configuration as zero.
// RULE20: Status shifted out full duplex, MSB first.
package lamp_link_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 5;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 11;
  localparam int DATA_BITS = 11;
  localparam int NUM_REGS = 32;
  localparam int NUM_OUT = 4;

  // ****************************************
  // Register indices and fields
  // ****************************************
  localparam logic [4:0] REG_OUT_ON = 5'h01;
  localparam logic [4:0] REG_CONFIG = 5'h02;
  localparam int CFG_PWM_EN = 0;
  localparam int CFG_DIR_DIS_LSB = 1;
  localparam int CFG_SENSE_TEMP = 5;
  localparam int CFG_SENSE_HIZ = 6;
  localparam int CFG_SENSE_SEL_LSB = 7;
  localparam logic [10:0] REG_RESET_VAL = 11'h000;

  // ****************************************
  // Timing
  // ****************************************
  localparam real CLK_MHZ = 40.0;
  localparam real SCLK_MAX_MHZ = 8.0;
  localparam int SCLK_DIV_MIN = int'(CLK_MHZ / SCLK_MAX_MHZ);
  localparam real RST_LOW_US = 10.0;
  localparam int RST_LOW_CYCLES = int'(RST_LOW_US * CLK_MHZ);
  localparam int WDOG_CYCLES = 1000;

  // ****************************************
  // Master command states
  // ****************************************
  typedef enum logic [2:0] {
    M_IDLE, M_RST, M_SETUP, M_LOW, M_HIGH, M_LAG
  } master_state_e;

endpackage

//--- rtl/lamp_switch_dev.sv
// Device end: serial slave, wake logic, outputs, fault and sense pins.
// Assumes link.sclk from the link clocks the slave; clk_i runs the core.
`timescale 1ns/1ps
module lamp_switch_dev #(
  parameter int WDOG_LEN = lamp_link_pkg::WDOG_CYCLES
) (
  // Core clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link
  lamp_link_if.device link,
  // Device status and outputs
  input wire logic [3:0] fault_cond_i,
  output logic [3:0] high_side_outputs_o,
  output logic awake_o,
  output logic watchdog_run_o,
  output logic [2:0] sense_mode_o,
  output logic sense_output_oe_n_o
);
  // Refuse a watchdog length that the 16-bit counter cannot hold
  if (WDOG_LEN < 2 || WDOG_LEN > 65536) begin : g_bad_wdog_len
    $error("WDOG_LEN out of range");
  end

  // ****************************************
  // Pin synchronisers into core domain
  // ****************************************
  logic [7:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
  logic rst_q_reg, rst_q_next;
  always_comb begin
    sync1_next = {link.cs_n, link.reset_n, link.wake, link.direct_control_inputs,
                  1'b0};
    sync2_next = sync1_reg;
    rst_q_next = sync2_reg[6];
  end
  // Select and reset pins idle high, so no false edge after reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= 8'hc0;
      sync2_reg <= 8'hc0;
      rst_q_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      rst_q_reg <= rst_q_next;
    end
  end
  logic cs_n_s, rst_n_s, wake_s;
  logic [3:0] din_s;
  assign cs_n_s = sync2_reg[7];
  assign rst_n_s = sync2_reg[6];
  assign wake_s = sync2_reg[5];
  assign din_s = sync2_reg[4:1];

  // ****************************************
  // Link domain: receive on fall, transmit on rise
  // ****************************************
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [4:0] cnt_reg;
  logic [15:0] status_word, status_hold_reg, status_hold_next;
  logic tx_first_reg;
  logic [15:0] frame_reg;
  logic frame_tog_reg;
  // Receive shifter, held while deselected
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_reg <= 5'h00;
    end else begin
      rx_reg <= {rx_reg[14:0], link.mosi}; // RULE1 RULE3
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
  // Frozen status taken at the first rise, advanced on each later rise
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      tx_first_reg <= 1'b1;
      tx_reg <= 16'h0000;
    end else if (tx_first_reg) begin
      tx_first_reg <= 1'b0;
      tx_reg <= status_hold_reg; // RULE5
    end else begin
      tx_reg <= {tx_reg[14:0], 1'b0}; // RULE2 RULE20
    end
  end
  // Top bit stands through the first fall; later bits follow each rise
  assign link.miso_o = tx_first_reg ? status_hold_reg[15] : tx_reg[15]; // RULE20
  assign link.miso_oe_n = link.cs_n; // RULE6
  // Commit full frames at select rise; toggle tells the core
  always_ff @(posedge link.cs_n or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_reg <= 16'h0000;
      frame_tog_reg <= 1'b0;
    end else if (cnt_reg == 5'(lamp_link_pkg::FRAME_BITS)) begin
      frame_reg <= rx_reg; // RULE4
      frame_tog_reg <= ~frame_tog_reg;
    end
  end

  // ****************************************
  // Core domain: frame take-over and registers
  // ****************************************
  logic [2:0] tog_reg, tog_next;
  logic [10:0] regs_reg [lamp_link_pkg::NUM_REGS];
  logic [10:0] regs_next [lamp_link_pkg::NUM_REGS];
  logic asleep;
  logic wake_any;
  assign wake_any = rst_n_s | wake_s | (|din_s); // RULE12 RULE14 RULE17
  assign asleep = ~wake_any;
  always_comb begin
    tog_next = {tog_reg[1:0], frame_tog_reg};
    for (int i = 0; i < lamp_link_pkg::NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (!rst_n_s || asleep) begin
      for (int i = 0; i < lamp_link_pkg::NUM_REGS; i++) begin
        regs_next[i] = lamp_link_pkg::REG_RESET_VAL; // RULE12 RULE19
      end
    end else if (tog_reg[2] != tog_reg[1]) begin
      regs_next[frame_reg[lamp_link_pkg::ADDR_MSB:lamp_link_pkg::ADDR_LSB]] =
        frame_reg[lamp_link_pkg::DATA_BITS-1:0]; // RULE9
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tog_reg <= 3'h0;
      for (int i = 0; i < lamp_link_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= lamp_link_pkg::REG_RESET_VAL;
      end
    end else begin
      tog_reg <= tog_next;
      regs_reg <= regs_next;
    end
  end

  // ****************************************
  // Outputs, watchdog, fault, sense
  // ****************************************
  logic [10:0] cfg, on_bits;
  logic [3:0] dir_dis;
  logic [3:0] hs_next;
  logic [15:0] wd_reg, wd_next;
  logic wd_run_reg, wd_run_next, awake_next;
  logic fault_n_reg, fault_n_next;
  logic [2:0] sense_next;
  logic sense_oe_n_next;
  logic pwm_tick;
  assign cfg = regs_reg[lamp_link_pkg::REG_CONFIG];
  assign on_bits = regs_reg[lamp_link_pkg::REG_OUT_ON];
  assign dir_dis = cfg[lamp_link_pkg::CFG_DIR_DIS_LSB +: 4];
  assign pwm_tick = cfg[lamp_link_pkg::CFG_PWM_EN] & din_s[0]; // RULE15
  assign status_word = {4'h0, fault_cond_i, high_side_outputs_o, ~fault_n_reg,
                        wd_run_reg, awake_o, asleep};
  always_comb begin
    if (cfg[lamp_link_pkg::CFG_PWM_EN]) begin
      hs_next = on_bits[3:0] & {4{pwm_tick}}; // RULE15
    end else begin
      hs_next = (din_s & ~dir_dis) | on_bits[3:0]; // RULE14
    end
    if (asleep) begin
      hs_next = 4'h0;
    end
    wd_run_next = wd_run_reg;
    wd_next = wd_reg;
    if (!rst_n_s) begin
      wd_run_next = 1'b0;
    end else if (!rst_q_reg) begin
      wd_run_next = 1'b1; // RULE13
      wd_next = 16'h0000;
    end else if (wd_run_reg && wd_reg != 16'(WDOG_LEN - 1)) begin
      wd_next = wd_reg + 16'h0001;
    end
    awake_next = wake_any;
    // Status frozen once select low is seen; needs three clocks of lead
    status_hold_next = cs_n_s ? status_word : status_hold_reg; // RULE5
    fault_n_next = ~(|fault_cond_i); // RULE16
    sense_next = {cfg[lamp_link_pkg::CFG_SENSE_TEMP],
                  cfg[lamp_link_pkg::CFG_SENSE_SEL_LSB +: 2]}; // RULE18
    sense_oe_n_next = cfg[lamp_link_pkg::CFG_SENSE_HIZ] | asleep; // RULE18
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      high_side_outputs_o <= 4'h0;
      wd_reg <= 16'h0000;
      wd_run_reg <= 1'b0;
      awake_o <= 1'b0;
      status_hold_reg <= 16'h0000;
      fault_n_reg <= 1'b1;
      sense_mode_o <= 3'h0;
      sense_output_oe_n_o <= 1'b1;
    end else begin
      high_side_outputs_o <= hs_next;
      wd_reg <= wd_next;
      wd_run_reg <= wd_run_next;
      awake_o <= awake_next;
      status_hold_reg <= status_hold_next;
      fault_n_reg <= fault_n_next;
      sense_mode_o <= sense_next;
      sense_output_oe_n_o <= sense_oe_n_next;
    end
  end
  assign watchdog_run_o = wd_run_reg;
  // Open drain: enable low pulls the pin low
  assign link.fault_indicator_n_oe_n = fault_n_reg; // RULE16
endmodule

//--- rtl/lamp_switch_host.sv
// Host end: SPI master sending one 16-bit command per request.
// Assumes clk_i is 40 MHz; sclk is derived by a divider here.
`timescale 1ns/1ps
module lamp_switch_host #(
  parameter int RST_LOW = lamp_link_pkg::RST_LOW_CYCLES,
  parameter int DIV = lamp_link_pkg::SCLK_DIV_MIN
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link
  lamp_link_if.host link,
  // User commands
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic reset_req_i,
  input wire logic wake_i,
  input wire logic [3:0] direct_i,
  output logic cmd_ready_o,
  output logic [15:0] status_o,
  output logic status_valid_o,
  output logic fault_o
);
  // Refuse a divider faster than the link allows or counts beyond 16 bits
  if (DIV < lamp_link_pkg::SCLK_DIV_MIN || DIV > 65536) begin : g_bad_div
    $error("DIV out of range for link");
  end
  if (RST_LOW < 1 || RST_LOW > 65536) begin : g_bad_rst_low
    $error("RST_LOW out of range");
  end

  lamp_link_pkg::master_state_e st_reg, st_next;
  logic [15:0] tx_reg, tx_next, rx_reg, rx_next, stat_next;
  logic [4:0] bit_reg, bit_next;
  logic [15:0] cnt_reg, cnt_next;
  logic cs_reg, cs_next, sclk_reg, sclk_next, rst_reg, rst_next, sv_next;
  logic [1:0] miso_s_reg, fault_s_reg;

  // ****************************************
  // Master sequencer
  // ****************************************
  always_comb begin
    st_next = st_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    bit_next = bit_reg;
    cnt_next = cnt_reg + 16'h0001;
    cs_next = cs_reg;
    sclk_next = 1'b0; // RULE7 RULE8
    rst_next = rst_reg;
    stat_next = status_o;
    sv_next = 1'b0;
    unique case (st_reg)
      lamp_link_pkg::M_IDLE: begin
        cnt_next = 16'h0000;
        if (reset_req_i) begin
          st_next = lamp_link_pkg::M_RST;
          rst_next = 1'b0;
        end else if (cmd_valid_i) begin
          st_next = lamp_link_pkg::M_SETUP;
          tx_next = cmd_data_i;
          cs_next = 1'b0;
          bit_next = 5'h00;
        end
      end
      lamp_link_pkg::M_RST: begin
        if (cnt_reg == 16'(RST_LOW - 1)) begin
          rst_next = 1'b1; // RULE11
          st_next = lamp_link_pkg::M_IDLE;
        end
      end
      lamp_link_pkg::M_SETUP, lamp_link_pkg::M_LOW: begin
        // Next bit one clock after the fall, never on the sampling edge
        if (st_reg == lamp_link_pkg::M_LOW && cnt_reg == 16'h0000) begin
          tx_next = {tx_reg[14:0], 1'b0}; // RULE3
        end
        if (cnt_reg == 16'(DIV - 1)) begin
          cnt_next = 16'h0000;
          sclk_next = 1'b1; // RULE10
          st_next = lamp_link_pkg::M_HIGH;
        end
      end
      lamp_link_pkg::M_HIGH: begin
        sclk_next = 1'b1;
        if (cnt_reg == 16'(DIV - 1)) begin
          cnt_next = 16'h0000;
          sclk_next = 1'b0;
          rx_next = {rx_reg[14:0], miso_s_reg[1]};
          bit_next = bit_reg + 5'h01;
          st_next = (bit_reg == 5'h0f) ? lamp_link_pkg::M_LAG : lamp_link_pkg::M_LOW;
        end
      end
      lamp_link_pkg::M_LAG: begin
        if (cnt_reg == 16'(DIV - 1)) begin
          cs_next = 1'b1;
          stat_next = rx_reg;
          sv_next = 1'b1;
          st_next = lamp_link_pkg::M_IDLE;
        end
      end
      default: st_next = lamp_link_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= lamp_link_pkg::M_IDLE;
      tx_reg <= 16'h0000;
      rx_reg <= 16'h0000;
      bit_reg <= 5'h00;
      cnt_reg <= 16'h0000;
      cs_reg <= 1'b1;
      sclk_reg <= 1'b0;
      rst_reg <= 1'b1;
      status_o <= 16'h0000;
      status_valid_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      miso_s_reg <= 2'h0;
      fault_s_reg <= 2'h3;
      fault_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      bit_reg <= bit_next;
      cnt_reg <= cnt_next;
      cs_reg <= cs_next;
      sclk_reg <= sclk_next;
      rst_reg <= rst_next;
      status_o <= stat_next;
      status_valid_o <= sv_next;
      cmd_ready_o <= (st_next == lamp_link_pkg::M_IDLE);
      miso_s_reg <= {miso_s_reg[0], link.miso};
      fault_s_reg <= {fault_s_reg[0], link.fault_indicator_n};
      fault_o <= ~fault_s_reg[1];
    end
  end

  // Pins straight from flip-flops or user levels
  assign link.cs_n = cs_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = tx_reg[15]; // RULE3 RULE9
  assign link.reset_n = rst_reg;
  assign link.wake = wake_i;
  assign link.direct_control_inputs = direct_i; // RULE15
endmodule

//--- verif/lamp_link_props.sv
// Assertions on the serial link between host and lamp switch device.
// Assumes link signals as plain inputs, sampled on clk_i, resetn_i low.
`timescale 1ns/1ps
module lamp_link_props #(
  parameter int RST_LOW = 100
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic reset_n
);
  logic [4:0] rise_cnt_reg, rise_cnt_next;
  logic [15:0] rst_low_reg, rst_low_next;
  logic sclk_q_reg;

  // ****************************************
  // Helper counters
  // ****************************************
  // Serial clock rises per frame, reset pin low time
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    rst_low_next = reset_n ? 16'h0000 : rst_low_reg + 16'h0001;
    if (cs_n) begin
      rise_cnt_next = 5'h00;
    end else if (sclk && !sclk_q_reg) begin
      rise_cnt_next = rise_cnt_reg + 5'h01;
    end
  end

  // Register helper state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_cnt_reg <= 5'h00;
      rst_low_reg <= 16'h0000;
      sclk_q_reg <= 1'h0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      rst_low_reg <= rst_low_next;
      sclk_q_reg <= sclk;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_high_phase;
    sclk[*4] ##1 !sclk;
  endsequence
  sequence s_low_phase;
    !sclk[*4];
  endsequence
  property p_so_enable;
    miso_oe_n == cs_n;
  endproperty
  property p_cs_edge_clk_low;
    $changed(cs_n) |-> !sclk && !$past(sclk);
  endproperty
  property p_idle_clk_low;
    cs_n |-> !sclk;
  endproperty
  property p_clk_high_width;
    $rose(sclk) |=> s_high_phase;
  endproperty
  property p_clk_low_width;
    $fell(sclk) |=> s_low_phase;
  endproperty
  property p_mosi_steady;
    sclk |-> $stable(mosi);
  endproperty
  property p_so_steady_low;
    !cs_n && !sclk && $past(!cs_n) |-> $stable(miso_o);
  endproperty
  property p_frame_len;
    $rose(cs_n) |-> rise_cnt_reg == 5'h10;
  endproperty
  property p_reset_width;
    $rose(reset_n) |-> rst_low_reg >= RST_LOW;
  endproperty
  a_so_enable: assert property (p_so_enable)
    else $error("serial output enable differs from select");
  a_cs_edge_clk_low: assert property (p_cs_edge_clk_low)
    else $error("select moved while serial clock high");
  a_idle_clk_low: assert property (p_idle_clk_low)
    else $error("serial clock high while idle");
  a_clk_high_width: assert property (p_clk_high_width)
    else $error("serial clock high phase wrong");
  a_clk_low_width: assert property (p_clk_low_width)
    else $error("serial clock low phase too short");
  a_mosi_steady: assert property (p_mosi_steady)
    else $error("serial input moved while clock high");
  a_so_steady_low: assert property (p_so_steady_low)
    else $error("serial output moved while clock low");
  a_frame_len: assert property (p_frame_len)
    else $error("frame not sixteen clocks");
  a_reset_width: assert property (p_reset_width)
    else $error("reset pin pulse too short");
endmodule

//--- verif/lamp_switch_spi_slave_and_wake_test.sv
// Testbench joining host and device ends over the link interface.
// Assumes the host makes the link clock; bench resolves shared pins.
`timescale 1ns/1ps
module lamp_switch_spi_slave_and_wake_test;
  localparam int RST_LOW = 100;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic cmd_valid_i = 1'h0;
  logic [15:0] cmd_data_i = 16'h0000;
  logic reset_req_i = 1'h0;
  logic wake_i = 1'h1;
  logic [3:0] direct_i = 4'h0;
  logic [3:0] fault_cond_i = 4'h0;
  logic cmd_ready_o, status_valid_o, fault_o, flip_reg = 1'h0;
  logic [15:0] status_o, mosi_cap, miso_cap;
  logic [3:0] high_side_outputs_o;
  logic awake_o, watchdog_run_o, sense_output_oe_n_o;
  logic [2:0] sense_mode_o;
  int n_mismatch = 0;
  int n_tests = 0;

  // ****************************************
  // Design, wires and checker
  // ****************************************
  lamp_link_if link ();
  lamp_switch_host #(.RST_LOW(RST_LOW), .DIV(5)) lamp_switch_host_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .link(link), .cmd_valid_i(cmd_valid_i), .cmd_data_i(cmd_data_i),
    .reset_req_i(reset_req_i), .wake_i(wake_i), .direct_i(direct_i),
    .cmd_ready_o(cmd_ready_o), .status_o(status_o), .status_valid_o(status_valid_o),
    .fault_o(fault_o));
  lamp_switch_dev #(.WDOG_LEN(16)) lamp_switch_dev_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(link), .fault_cond_i(fault_cond_i), .high_side_outputs_o(high_side_outputs_o),
    .awake_o(awake_o), .watchdog_run_o(watchdog_run_o), .sense_mode_o(sense_mode_o),
    .sense_output_oe_n_o(sense_output_oe_n_o));
  lamp_link_props #(.RST_LOW(RST_LOW)) lamp_link_props_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
    .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n), .reset_n(link.reset_n));

  // Clock, released serial output toggles, fault pin pulled up
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) flip_reg <= ~flip_reg;
  assign link.miso = link.miso_oe_n ? flip_reg : link.miso_o;
  assign link.fault_indicator_n = link.fault_indicator_n_oe_n;
  // Wire monitors: command on clock rise, status on clock fall
  always @(posedge link.sclk) if (!link.cs_n) mosi_cap <= {mosi_cap[14:0], link.mosi};
  always @(negedge link.sclk) if (!link.cs_n) miso_cap <= {miso_cap[14:0], link.miso};

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up(input int i);
    if (i >= 400) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One frame; status compared under a mask
  task automatic send(input logic [15:0] data, input logic [15:0] mask, input logic [15:0] exp);
    int i;
    i = 0;
    while (cmd_ready_o !== 1'h1 && i < 400) begin
      @(negedge clk_i);
      i++;
    end
    give_up(i);
    cmd_valid_i = 1'h1;
    cmd_data_i = data;
    @(negedge clk_i);
    cmd_valid_i = 1'h0;
    i = 0;
    while (status_valid_o !== 1'h1 && i < 400) begin
      @(negedge clk_i);
      i++;
    end
    give_up(i);
    check(mosi_cap, data);
    check(miso_cap & mask, exp & mask);
    check(status_o & mask, exp & mask);
    wait_cyc(8);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_sleep();
    int i;
    wake_i = 1'h0;
    reset_req_i = 1'h1;
    @(negedge clk_i);
    reset_req_i = 1'h0;
    wait_cyc(8);
    check(awake_o, 1'h0);
    check(high_side_outputs_o, 4'h0);
    check(watchdog_run_o, 1'h0);
    wake_i = 1'h1;
    wait_cyc(5);
    check(awake_o, 1'h1);
    wake_i = 1'h0;
    for (i = 0; i < 4; i++) begin
      wait_cyc(5);
      direct_i = 4'h1 << i;
      wait_cyc(5);
      check(awake_o, 1'h1);
      check(high_side_outputs_o, 4'h1 << i);
      direct_i = 4'h0;
    end
    wake_i = 1'h1;
    i = 0;
    while (link.reset_n !== 1'h1 && i < 400) begin
      @(negedge clk_i);
      i++;
    end
    give_up(i);
    wait_cyc(5);
    check(watchdog_run_o, 1'h1);
    $display("t_reset_sleep done");
  endtask
  task automatic t_outputs();
    send({lamp_link_pkg::REG_OUT_ON, 11'h00a}, 16'hfffb, 16'h0002);
    check(high_side_outputs_o, 4'ha);
    send({5'h03, 11'h7f5}, 16'hfffb, 16'h00a2);
    check(high_side_outputs_o, 4'ha);
    $display("t_outputs done");
  endtask
  task automatic t_sense();
    send({lamp_link_pkg::REG_CONFIG, 11'h120}, 16'hfffb, 16'h00a2);
    check(sense_mode_o, 3'h6);
    check(sense_output_oe_n_o, 1'h0);
    send({lamp_link_pkg::REG_CONFIG, 11'h160}, 16'hfffb, 16'h00a2);
    check(sense_output_oe_n_o, 1'h1);
    $display("t_sense done");
  endtask
  task automatic t_fault();
    fault_cond_i = 4'h4;
    wait_cyc(5);
    check(link.fault_indicator_n, 1'h0);
    check(fault_o, 1'h1);
    send({5'h03, 11'h000}, 16'h0f0b, 16'h040a);
    fault_cond_i = 4'h0;
    wait_cyc(5);
    check(link.fault_indicator_n, 1'h1);
    check(fault_o, 1'h0);
    $display("t_fault done");
  endtask
  task automatic t_pwm();
    send({lamp_link_pkg::REG_CONFIG, 11'h001}, 16'hf00b, 16'h0002);
    send({lamp_link_pkg::REG_OUT_ON, 11'h001}, 16'hf00b, 16'h0002);
    direct_i = 4'h1;
    wait_cyc(5);
    check(high_side_outputs_o, 4'h1);
    direct_i = 4'h0;
    wait_cyc(5);
    check(high_side_outputs_o, 4'h0);
    $display("t_pwm done");
  endtask
  // Reset pin pulse mid-run must drop the PWM setting and on bits
  task automatic t_clear();
    int i;
    reset_req_i = 1'h1;
    @(negedge clk_i);
    reset_req_i = 1'h0;
    i = 0;
    while (link.reset_n !== 1'h1 && i < 400) begin
      @(negedge clk_i);
      i++;
    end
    give_up(i);
    wait_cyc(5);
    direct_i = 4'h2;
    wait_cyc(5);
    check(high_side_outputs_o, 4'h2);
    direct_i = 4'h0;
    $display("t_clear done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge clk_i);
    resetn_i = 1'h1;
    wait_cyc(4);
    t_reset_sleep();
    t_outputs();
    t_sense();
    t_fault();
    t_pwm();
    t_clear();
    finish_test();
  end
endmodule
